// File: hw/ispc_pkg.sv
// shared constants and types of the programming command unit
package ispc_pkg;
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
  localparam logic [IR_W-1:0] IR_ENABLE = 4'h9;
  localparam logic [IR_W-1:0] IR_ERASE = 4'hA;
  localparam logic [IR_W-1:0] IR_PROGRAM = 4'hB;
  localparam logic [IR_W-1:0] IR_VERIFY = 4'hC;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam int ID_W = 32;
  localparam int BUSY_W = 24;
  localparam int CLK_MHZ = 100;
  localparam int ERASE_PW_MS = 100;
  localparam int PROG_PW_MS = 10;
  localparam int VERIFY_PW_US = 10;
  localparam int ERASE_PW_CYC = ERASE_PW_MS * 1000 * CLK_MHZ;
  localparam int PROG_PW_CYC = PROG_PW_MS * 1000 * CLK_MHZ;
  localparam int VERIFY_PW_CYC = VERIFY_PW_US * CLK_MHZ;
  localparam int TLR_TMS_HIGH = 5;

  typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_PROG, OP_VERIFY} ispc_op_t;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } ispc_tap_t;
endpackage

// File: hw/ispc_sync.sv
// two-stage synchroniser for the test port pins
`timescale 1ns/10ps
`default_nettype none
module ispc_sync #(
  parameter int W = 3
) (
  input wire logic CORE_CLK, // core clock
  input wire logic RST_N, // synchronous reset, active low
  input wire logic [W-1:0] async_in, // pin levels
  output logic [W-1:0] sync_out // synchronised levels
);
  logic [W-1:0] meta_r;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // ispc_sync
`default_nettype wire

// File: hw/ispc_unit.sv
// test-port command unit for in-system programming of the configuration array
// What this block and its controller do
// RL1: enable instruction arms erase, program, verify
// RL2: armed erase clears the whole array
// RL3: armed program writes shift register to row
// RL4: verify copies addressed row into shift register
// RL5: verify drives user pins to configured state
// RL6: controller arms before programming operations
// RL7: sample on TCK rise, TDO on fall
// RL8: bypass and identification instruction codes
// RL9: controller waits out each operation pulse except the final verify, which the test ends during
`timescale 1ns/10ps
`default_nettype none
module ispc_unit
  import ispc_pkg::*;
#(
  parameter int ADDR_W = 5,
  parameter int DATA_W = 32,
  parameter int PIN_W = 8,
  parameter logic [ID_W-1:0] IDCODE = 32'h0A5C_3001, // arbitrary value
  parameter logic [DATA_W-1:0] ERASED = '1,
  parameter int ERASE_CYC = ERASE_PW_CYC,
  parameter int PROG_CYC = PROG_PW_CYC,
  parameter int VERIFY_CYC = VERIFY_PW_CYC
) (
  input wire logic CORE_CLK, // core clock, 100 MHz
  input wire logic RST_N, // synchronous reset, active low
  input wire logic TCK, // test clock pin
  input wire logic TMS, // test mode select pin
  input wire logic TDI, // test data in pin
  output logic TDO_O, // test data out level
  output logic TDO_OE, // test data out driven
  input wire logic [PIN_W-1:0] USER_OUT, // normal function outputs
  input wire logic [PIN_W-1:0] VERIFY_PINS, // user state during verify
  output logic [PIN_W-1:0] PIN_OUT, // user pins
  output logic ARMED, // unit armed
  output logic BUSY // operation pulse running
);
  localparam int ROWS = 2 ** ADDR_W;
  localparam int PGM_W = ADDR_W + DATA_W;
  logic [2:0] pins_s;
  logic tck_d_r, tck_rise, tck_fall, tms_s, tdi_s;
  ispc_tap_t tap_r, tap_nxt;
  logic [2:0] tlr_cnt_r;
  logic [IR_W-1:0] ir_r, ir_sr_r, op_ir;
  logic [PGM_W-1:0] pgm_sr_r;
  logic [ID_W-1:0] id_sr_r;
  logic byp_r, armed_r, busy_r;
  logic [DATA_W-1:0] mem_r [ROWS];
  logic [ADDR_W-1:0] sr_addr;
  logic [DATA_W-1:0] sr_data, rd_row;
  logic pgm_op, sel_pgm, exec, erase_go, prog_go, verify_go;
  logic [BUSY_W-1:0] busy_cnt_r;
  ispc_op_t op_r;
  logic vfy_busy, dr_bit, shifting;

  ispc_sync #(.W(3)) u_sync (
    .CORE_CLK(CORE_CLK),
    .RST_N(RST_N),
    .async_in({TCK, TMS, TDI}),
    .sync_out(pins_s)
  );

  assign tms_s = pins_s[1];
  assign tdi_s = pins_s[0];
  assign tck_rise = pins_s[2] && !tck_d_r; // [RL7]
  assign tck_fall = !pins_s[2] && tck_d_r; // [RL7]

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      tck_d_r <= 1'b0;
    else
      tck_d_r <= pins_s[2];
  end
  always_comb
  begin
    tap_nxt = tap_r;
    unique case (tap_r)
      TLR: tap_nxt = tms_s ? TLR : RTI;
      RTI: tap_nxt = tms_s ? SEL_DR : RTI;
      SEL_DR: tap_nxt = tms_s ? SEL_IR : CAP_DR;
      CAP_DR: tap_nxt = tms_s ? EX1_DR : SH_DR;
      SH_DR: tap_nxt = tms_s ? EX1_DR : SH_DR;
      EX1_DR: tap_nxt = tms_s ? UPD_DR : PA_DR;
      PA_DR: tap_nxt = tms_s ? EX2_DR : PA_DR;
      EX2_DR: tap_nxt = tms_s ? UPD_DR : SH_DR;
      UPD_DR: tap_nxt = tms_s ? SEL_DR : RTI;
      SEL_IR: tap_nxt = tms_s ? TLR : CAP_IR;
      CAP_IR: tap_nxt = tms_s ? EX1_IR : SH_IR;
      SH_IR: tap_nxt = tms_s ? EX1_IR : SH_IR;
      EX1_IR: tap_nxt = tms_s ? UPD_IR : PA_IR;
      PA_IR: tap_nxt = tms_s ? EX2_IR : PA_IR;
      EX2_IR: tap_nxt = tms_s ? UPD_IR : SH_IR;
      UPD_IR: tap_nxt = tms_s ? SEL_DR : RTI;
    endcase
  end
  // tms held high forces the test logic reset even if the state is lost
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      tap_r <= TLR;
      tlr_cnt_r <= '0;
    end
    else if (tck_rise)
    begin
      tlr_cnt_r <= tms_s ? ((tlr_cnt_r == 3'(TLR_TMS_HIGH)) ? tlr_cnt_r : tlr_cnt_r + 3'h1) : '0;
      tap_r <= (tms_s && tlr_cnt_r == 3'(TLR_TMS_HIGH - 1)) ? TLR : tap_nxt; // [RL7]
    end
  end

  // instruction path; armed stays set across operations until test reset
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      ir_r <= IR_IDCODE;
      ir_sr_r <= IR_CAPTURE;
      armed_r <= 1'b0;
    end
    else if (tck_rise)
    begin
      unique case (tap_r)
        TLR:
        begin
          ir_r <= IR_IDCODE;
          armed_r <= 1'b0;
        end
        CAP_IR: ir_sr_r <= IR_CAPTURE;
        SH_IR: ir_sr_r <= {tdi_s, ir_sr_r[IR_W-1:1]}; // [RL7]
        UPD_IR:
        begin
          ir_r <= ir_sr_r;
          if (ir_sr_r == IR_ENABLE)
            armed_r <= 1'b1; // [RL1] [RL6]
        end
        default: ;
      endcase
    end
  end
  assign pgm_op = ir_r == IR_ERASE || ir_r == IR_PROGRAM || ir_r == IR_VERIFY;
  assign sel_pgm = ir_r == IR_ENABLE || (pgm_op && armed_r); // [RL1]
  assign sr_addr = pgm_sr_r[PGM_W-1 -: ADDR_W];
  assign sr_data = pgm_sr_r[DATA_W-1:0];
  assign rd_row = mem_r[sr_addr];
  // ir_r loads on the very rise that leaves update-ir, so decode the new code there
  assign op_ir = (tap_r == UPD_IR) ? ir_sr_r : ir_r;
  // operations fire when the tap settles in run-test/idle after an update
  assign exec = tck_rise && (tap_r == UPD_DR || tap_r == UPD_IR) && !tms_s;
  assign erase_go = exec && armed_r && op_ir == IR_ERASE; // [RL1] [RL2]
  assign prog_go = exec && armed_r && op_ir == IR_PROGRAM; // [RL1] [RL3]
  assign verify_go = exec && armed_r && op_ir == IR_VERIFY; // [RL1] [RL4]
  // capture keeps the programming register so verified data survives to the next scan
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      pgm_sr_r <= '0;
      id_sr_r <= IDCODE;
      byp_r <= 1'b0;
    end
    else if (verify_go)
      pgm_sr_r[DATA_W-1:0] <= rd_row; // [RL4]
    else if (tck_rise && tap_r == CAP_DR)
    begin
      id_sr_r <= IDCODE; // [RL8]
      byp_r <= 1'b0; // [RL8]
    end
    else if (tck_rise && tap_r == SH_DR)
    begin
      if (sel_pgm)
        pgm_sr_r <= {tdi_s, pgm_sr_r[PGM_W-1:1]};
      else if (ir_r == IR_IDCODE)
        id_sr_r <= {tdi_s, id_sr_r[ID_W-1:1]};
      else
        byp_r <= tdi_s; // [RL8]
    end
  end
  // the array is nonvolatile, so it has no reset
  always_ff @(posedge CORE_CLK)
  begin
    if (erase_go)
    begin
      for (int i = 0; i < ROWS; i++)
        mem_r[i] <= ERASED; // [RL2]
    end
    else if (prog_go)
      mem_r[sr_addr] <= sr_data; // [RL3]
  end
  // pulse timer reports busy and times the verify pin state; a new operation restarts it
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      busy_cnt_r <= '0;
      busy_r <= 1'b0;
      op_r <= OP_NONE;
    end
    else if (erase_go || prog_go || verify_go)
    begin
      busy_r <= 1'b1;
      op_r <= erase_go ? OP_ERASE : (prog_go ? OP_PROG : OP_VERIFY);
      busy_cnt_r <= erase_go ? BUSY_W'(ERASE_CYC - 1) :
        (prog_go ? BUSY_W'(PROG_CYC - 1) : BUSY_W'(VERIFY_CYC - 1)); // [RL9]
    end
    else if (busy_cnt_r != '0)
      busy_cnt_r <= busy_cnt_r - BUSY_W'(1);
    else
    begin
      busy_r <= 1'b0;
      op_r <= OP_NONE;
    end
  end
  assign vfy_busy = busy_r && op_r == OP_VERIFY;
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      PIN_OUT <= '0;
    else
      PIN_OUT <= vfy_busy ? VERIFY_PINS : USER_OUT; // [RL5]
  end

  assign shifting = tap_r == SH_DR || tap_r == SH_IR;
  assign dr_bit = sel_pgm ? pgm_sr_r[0] : ((ir_r == IR_IDCODE) ? id_sr_r[0] : byp_r);
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      TDO_O <= 1'b0;
      TDO_OE <= 1'b0;
    end
    else if (tck_fall)
    begin
      TDO_O <= (tap_r == SH_IR) ? ir_sr_r[0] : dr_bit; // [RL7]
      TDO_OE <= shifting; // [RL7]
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      ARMED <= 1'b0;
      BUSY <= 1'b0;
    end
    else
    begin
      ARMED <= armed_r;
      BUSY <= busy_r;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  property p_arm_set;
    tck_rise && tap_r == UPD_IR && ir_sr_r == IR_ENABLE |=> armed_r ##1 ARMED;
  endproperty
  a_arm_set: assert property (p_arm_set) else $error("enable did not arm"); // [RL1]
  property p_refuse;
    exec && !armed_r && !busy_r |=> !busy_r;
  endproperty
  a_refuse: assert property (p_refuse) else $error("operation ran unarmed"); // [RL1]
  property p_erase;
    erase_go |=> mem_r[0] == ERASED && mem_r[ROWS-1] == ERASED;
  endproperty
  a_erase: assert property (p_erase) else $error("erase left a row set"); // [RL2]
  property p_prog;
    prog_go |=> mem_r[$past(sr_addr)] == $past(sr_data);
  endproperty
  a_prog: assert property (p_prog) else $error("program wrote wrong row"); // [RL3]
  property p_verify;
    verify_go |=> sr_data == $past(rd_row) && sr_addr == $past(sr_addr);
  endproperty
  a_verify: assert property (p_verify) else $error("verify copy wrong"); // [RL4]
  property p_pins;
    verify_go |=> ##1 PIN_OUT == $past(VERIFY_PINS) ##1 BUSY;
  endproperty
  a_pins: assert property (p_pins) else $error("pins not in verify state"); // [RL5]
  property p_tdo_fall;
    $changed(TDO_O) || $changed(TDO_OE) |-> $past(tck_fall);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off a fall"); // [RL7]
  property p_tdo_z;
    tck_fall && !shifting |=> !TDO_OE;
  endproperty
  a_tdo_z: assert property (p_tdo_z) else $error("tdo driven outside shift"); // [RL7]
  property p_bypass;
    tck_rise && tap_r == CAP_DR && ir_r == IR_BYPASS |=> !byp_r;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass capture not zero"); // [RL8]
  property p_idcode;
    tck_rise && tap_r == CAP_DR && ir_r == IR_IDCODE |=> id_sr_r == IDCODE;
  endproperty
  a_idcode: assert property (p_idcode) else $error("idcode not captured"); // [RL8]
endmodule // ispc_unit
`default_nettype wire

// File: tb/ispc_ctl_model.sv
// programming controller model on the far side of the test port
`timescale 1ns/10ps
`default_nettype none
module ispc_ctl_model (
  input wire logic CORE_CLK, // core clock
  input wire logic TDO_LINE, // test data out, pulled up
  input wire logic TDO_OE, // test data out driven
  output logic TCK, // test clock
  output logic TMS, // test mode select
  output logic TDI // test data in
);
  logic odd = 1'b0;
  logic oe_all = 1'b1;
  initial
  begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b1;
  end
  // tck runs only inside frames; 12 and 13 cycle periods average 125 ns
  task automatic step(input logic ms, input logic di, output logic dout);
    @(posedge CORE_CLK);
    TMS <= ms;
    TDI <= di;
    repeat (5) @(posedge CORE_CLK);
    dout = TDO_LINE;
    oe_all = oe_all & TDO_OE;
    TCK <= 1'b1;
    repeat (6 + odd) @(posedge CORE_CLK);
    TCK <= 1'b0;
    odd = ~odd;
  endtask
  task automatic nav(input logic [7:0] ms, input int n);
    logic d;
    for (int i = 0; i < n; i++) step(ms[i], 1'b1, d);
  endtask
  task automatic tlr();
    nav(8'h1F, 6);
  endtask
  task automatic scan_ir(input logic [3:0] code);
    logic d;
    nav(8'h03, 4);
    for (int i = 0; i < 4; i++) step(i == 3, code[i], d);
    nav(8'h01, 2);
  endtask
  task automatic scan_dr(input int n, input logic [63:0] din, output logic [63:0] dout);
    logic d;
    logic ok;
    dout = '0;
    nav(8'h01, 3);
    // only the shift steps count towards the drive-enable record
    oe_all = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], d);
      dout[i] = d;
    end
    ok = oe_all;
    nav(8'h01, 2);
    oe_all = ok;
  endtask
  // clock stands still while an operation pulse runs
  task automatic idle(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask
endmodule // ispc_ctl_model
`default_nettype wire

// File: tb/tb_jtag_isp_command_unit.sv
// testbench of the programming command unit
`timescale 1ns/10ps
`default_nettype none
module tb_jtag_isp_command_unit;
  import ispc_pkg::*;
  localparam logic [ID_W-1:0] TB_ID = 32'h1357_9BDF; // arbitrary value
  localparam int PCYC = 30;
  localparam int ECYC = 60;
  localparam int VCYC = 40;
  localparam logic [3:0] OPS [3] = '{IR_ERASE, IR_PROGRAM, IR_VERIFY};
  logic CORE_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] USER_OUT = 8'h00;
  logic [7:0] VERIFY_PINS = 8'hA5;
  logic TCK;
  logic TMS;
  logic TDI;
  logic TDO_O;
  logic TDO_OE;
  logic [7:0] PIN_OUT;
  logic ARMED;
  logic BUSY;
  logic tdo_line;
  logic tdo_q;
  logic [63:0] d;
  int run = 0;
  int last_len = 0;
  int cyc = 0;
  int errors = 0;
  int num_checks = 0;
  assign tdo_line = TDO_OE ? TDO_O : 1'b1;
  always #5 CORE_CLK = ~CORE_CLK;
  ispc_unit #(.IDCODE(TB_ID), .ERASE_CYC(ECYC), .PROG_CYC(PCYC), .VERIFY_CYC(VCYC)) i_dut (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO_O(TDO_O),
    .TDO_OE(TDO_OE), .USER_OUT(USER_OUT), .VERIFY_PINS(VERIFY_PINS), .PIN_OUT(PIN_OUT),
    .ARMED(ARMED), .BUSY(BUSY));
  ispc_ctl_model i_ctl (.CORE_CLK(CORE_CLK), .TDO_LINE(tdo_line), .TDO_OE(TDO_OE),
    .TCK(TCK), .TMS(TMS), .TDI(TDI));
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge CORE_CLK);
    #1;
  endtask
  // waits the pulse out, then judges how long busy stood
  task automatic chk_pulse(input string nm, input int n);
    i_ctl.idle(n + 12);
    #1;
    num_checks++;
    if (last_len < n || last_len > n + 1)
    begin
      errors++;
      $display("BAD %s expected %0d seen %0d", nm, n, last_len);
    end
  endtask
  always @(posedge CORE_CLK)
  begin
    cyc <= cyc + 1;
    USER_OUT <= USER_OUT + 8'h01;
    tdo_q <= TDO_O;
    if (cyc > 8 && TCK === 1'b1 && TDO_O !== tdo_q)
    begin
      errors++;
      $display("BAD tdo_edge expected %h seen %h", tdo_q, TDO_O);
    end
    if (BUSY === 1'b1)
      run <= run + 1;
    else if (run != 0)
    begin
      last_len <= run;
      run <= 0;
    end
    if (cyc == 40000)
    begin
      errors++;
      $display("BAD timeout expected 0 seen %0d", cyc);
      end_sim();
    end
  end
  task automatic t_reset();
    tick();
    chk("oe_reset", 0, TDO_OE);
    chk("armed_reset", 0, ARMED);
    chk("pins_normal", 8'(USER_OUT - 8'h01), PIN_OUT);
  endtask
  task automatic t_ident();
    i_ctl.tlr();
    i_ctl.scan_dr(ID_W, 64'h0, d);
    chk("idcode", TB_ID, d);
    chk("oe_shift", 1, i_ctl.oe_all);
    tick();
    chk("oe_idle", 0, TDO_OE);
    i_ctl.scan_ir(IR_BYPASS);
    i_ctl.scan_dr(8, 64'hB4, d);
    chk("bypass", 64'h68, d);
  endtask
  task automatic t_refuse();
    i_ctl.tlr();
    foreach (OPS[k])
    begin
      i_ctl.scan_ir(OPS[k]);
      tick();
      chk("busy_unarmed", 0, BUSY);
      i_ctl.scan_dr(8, 64'hB4, d);
      chk("dr_unarmed", 64'h68, d);
    end
    chk("armed_none", 0, ARMED);
  endtask
  task automatic t_prog();
    i_ctl.scan_ir(IR_ENABLE);
    tick();
    chk("armed", 1, ARMED);
    i_ctl.scan_dr(37, {27'h0000000, 5'h03, 32'hC0DE_1234}, d);
    i_ctl.scan_ir(IR_PROGRAM);
    tick();
    chk("busy_prog", 1, BUSY);
    chk_pulse("prog_len", PCYC);
    i_ctl.scan_dr(37, {27'h0000000, 5'h11, 32'h5A5A_0F0F}, d);
    chk_pulse("prog2_len", PCYC);
    i_ctl.scan_ir(IR_VERIFY);
    tick();
    chk("pins_verify", VERIFY_PINS, PIN_OUT);
    chk_pulse("verify_len", VCYC);
    chk("pins_after", 8'(USER_OUT - 8'h01), PIN_OUT);
    i_ctl.scan_dr(37, {27'h0000000, 5'h03, 32'h0000_0000}, d);
    chk("row17", {27'h0000000, 5'h11, 32'h5A5A_0F0F}, d);
    chk_pulse("verify2_len", VCYC);
    i_ctl.scan_dr(37, {27'h0000000, 5'h11, 32'h0000_0000}, d);
    chk("row3", {27'h0000000, 5'h03, 32'hC0DE_1234}, d);
    chk_pulse("verify3_len", VCYC);
  endtask
  task automatic t_erase();
    i_ctl.scan_ir(IR_ERASE);
    chk_pulse("erase_len", ECYC);
    i_ctl.scan_ir(IR_VERIFY);
    chk_pulse("verify4_len", VCYC);
    i_ctl.scan_dr(37, {27'h0000000, 5'h03, 32'h0000_0000}, d);
    chk("erased17", {27'h0000000, 5'h11, 32'hFFFF_FFFF}, d);
    chk_pulse("verify5_len", VCYC);
    i_ctl.scan_dr(37, 64'h0, d);
    chk("erased3", {27'h0000000, 5'h03, 32'hFFFF_FFFF}, d);
  endtask
  initial
  begin
    repeat (4) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    t_reset();
    t_ident();
    t_refuse();
    t_prog();
    t_erase();
    end_sim();
  end
endmodule // tb_jtag_isp_command_unit
`default_nettype wire
